// [ep_rx_pkg.sv]
// shared constants, enumerations and carriers of the endpoint receive control
package ep_rx_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 32;
    localparam logic [31:0] RX_CTRL_OFS = 32'h5000186E;
    localparam logic [31:0] EP_CFG_OFS = 32'h50001870;
    // receive control fields
    localparam int RXC_EN_BIT = 0;
    localparam int RXC_SKIP_BIT = 2;
    localparam int RXC_FLUSH_BIT = 3;
    localparam int RXC_WARN_LO = 5;
    localparam int RXC_WARN_HI = 6;
    // endpoint configuration fields
    localparam int EPC_NUM_LO = 0;
    localparam int EPC_NUM_HI = 3;
    localparam int EPC_ACTIVE_BIT = 4;
    localparam int EPC_ISO_BIT = 5;
    localparam int EPC_STALL_BIT = 7;
    localparam logic [15:0] REG_RESET = 16'h0000;
    // warning thresholds in empty bytes
    localparam logic [1:0] WARN_OFF = 2'h0;
    localparam logic [1:0] WARN_5 = 2'h1;
    localparam logic [1:0] WARN_9 = 2'h2;
    localparam int WARN_LIM_5 = 5;
    localparam int WARN_LIM_9 = 9;
    localparam int WARN_LIM_17 = 17;
    localparam int FIFO_DEPTH = 64;

    typedef enum logic [1:0] {
        TOK_OUT = 2'b00,
        TOK_IN = 2'b01,
        TOK_SETUP = 2'b10,
        TOK_OTHER = 2'b11
    } tok_kind_e;

    typedef enum logic [1:0] {
        HS_ACK = 2'b00,
        HS_NAK = 2'b01,
        HS_STALL = 2'b10
    } hs_pid_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX_DATA = 3'b001,
        ST_RX_SETUP = 3'b010,
        ST_SETUP_DUP = 3'b011,
        ST_DROP = 3'b100
    } rx_state_e;

    typedef struct packed {
        logic valid;
        tok_kind_e kind;
        logic [6:0] dev_addr;
        logic [3:0] ep_num;
    } token_s;

    typedef struct packed {
        logic valid;
        hs_pid_e pid;
    } handshake_s;

    typedef struct packed {
        logic stall;
        logic iso;
        logic active;
        logic [3:0] num;
    } ep_cfg_s;
endpackage

// [ep_rx_fifo.sv]
// receive fifo in flip-flops with flush of both pointers
`timescale 1ns/100ps
module ep_rx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = ep_rx_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // control
    input wire logic flush,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    input wire logic pop,
    // status and data
    output logic [WIDTH-1:0] pop_data,
    output logic full,
    output logic empty,
    output logic [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic do_push;
    logic do_pop;

    assign full = (count_r == (AW+1)'(DEPTH));
    assign empty = (count_r == '0);
    assign count = count_r;
    assign do_push = push && !full;
    assign do_pop = pop && !empty;

    always_ff @(posedge mclk) begin
        if (do_push) begin
            mem_r[wr_ptr_r] <= push_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || flush) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (do_push && !do_pop) begin
                count_r <= count_r + 1'b1;
            end else if (do_pop && !do_push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || flush) begin
            pop_data <= '0;
        end else if (do_pop) begin
            pop_data <= mem_r[rd_ptr_r];
        end
    end
endmodule

// [ep_token_match.sv]
// address match of a token and the endpoint's answer to an IN token
`timescale 1ns/100ps
module ep_token_match (
    // token and configuration
    input ep_rx_pkg::token_s tok,
    input wire logic [6:0] function_id_register,
    input ep_rx_pkg::ep_cfg_s cfg,
    // transmit side state
    input wire logic tx_fifo_en,
    input wire logic tx_fifo_empty,
    // results
    output logic hit,
    output ep_rx_pkg::handshake_s in_hs
);
    import ep_rx_pkg::*;

    // an inactive endpoint never matches, so nothing downstream answers
    assign hit = tok.valid && cfg.active && (tok.dev_addr == function_id_register)
                 && (tok.ep_num == cfg.num);

    always_comb begin
        in_hs = '{valid: 1'b0, pid: HS_ACK};
        if (hit && tok.kind == TOK_IN && tx_fifo_en) begin
            if (cfg.stall) begin
                in_hs = '{valid: 1'b1, pid: HS_STALL};
            end else if (tx_fifo_empty && !cfg.iso) begin
                in_hs = '{valid: 1'b1, pid: HS_NAK};
            end
        end
    end
endmodule

// [usb_endpoint_rx_control.sv]
// receive control and configuration of one usb endpoint with its receive fifo
// Functional notes
// - A one written to the flush bit empties the receive fifo, resets both pointers, idles.
// - With the skip bit set, SETUP tokens to this endpoint's address are ignored.
// - OUT reception is disarmed after each data packet and after a STALL to an OUT token.
// - SETUP packets are accepted whatever the receive enable bit holds.
// - A repeated SETUP with no non-SETUP token between is discarded but still ACKed.
// - A SETUP that cannot be taken for any other reason gets no handshake.
// - With halt set, an IN token meets STALL while the transmit fifo is enabled.
// - With halt set, an OUT token meets STALL while the receive fifo is enabled.
// - The halt bit never makes a STALL for a SETUP token.
// - An isochronous endpoint never sends NAK, neither for IN nor for OUT.
// - An active endpoint matches tokens on its 4-bit number and the 7-bit device address.
// - An inactive endpoint answers no token at all.
// - The endpoint number is a 4-bit read/write field in the low configuration bits.
// - The warning limit selects none, or a warning below 5, 9 or 17 empty bytes.
`timescale 1ns/100ps
module usb_endpoint_rx_control #(
    parameter int FIFO_DEPTH = ep_rx_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port
    input wire logic [ep_rx_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [ep_rx_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [ep_rx_pkg::DATA_W-1:0] reg_rdata,
    // device address from the function address register
    input wire logic [6:0] function_id_register,
    // bus engine: tokens and received packet
    input ep_rx_pkg::token_s tok,
    input wire logic pkt_byte_valid,
    input wire logic [7:0] pkt_byte,
    input wire logic pkt_end_ok,
    input wire logic pkt_end_err,
    // bus engine: transmit side state
    input wire logic tx_fifo_en,
    input wire logic tx_fifo_empty,
    // handshake to send
    output ep_rx_pkg::handshake_s hs,
    // firmware side of the receive fifo
    input wire logic fifo_pop,
    output logic [7:0] fifo_data,
    output logic [$clog2(FIFO_DEPTH):0] fifo_count,
    output logic rx_warn,
    output logic setup_seen
);
    import ep_rx_pkg::*;

    localparam int CW = $clog2(FIFO_DEPTH) + 1;

    ep_cfg_s cfg_r;
    logic rx_en_r;
    logic skip_r;
    logic [1:0] warn_sel_r;
    logic flush_pend_r;
    rx_state_e state_r;
    logic setup_held_r;
    logic ovf_r;
    handshake_s hs_r;
    logic [DATA_W-1:0] rdata_r;
    logic setup_seen_r;

    logic hit;
    handshake_s in_hs;
    logic wr_rxc;
    logic wr_epc;
    logic flush_do;
    logic fifo_full;
    logic fifo_empty;
    logic fifo_push;
    logic [CW-1:0] free_bytes;
    logic pkt_done;
    logic hit_setup;
    logic hit_out;

    // threshold in empty bytes for a warning code; zero disables
    function automatic logic [CW-1:0] warn_limit(input logic [1:0] sel);
        logic [CW-1:0] lim;
        lim = '0;
        case (sel)
            WARN_OFF: lim = '0;
            WARN_5: lim = CW'(WARN_LIM_5);
            WARN_9: lim = CW'(WARN_LIM_9);
            default: lim = CW'(WARN_LIM_17);
        endcase
        return lim;
    endfunction

    assign wr_rxc = reg_wr && (reg_addr == RX_CTRL_OFS);
    assign wr_epc = reg_wr && (reg_addr == EP_CFG_OFS);
    assign pkt_done = pkt_end_ok || pkt_end_err;
    assign hit_setup = hit && tok.kind == TOK_SETUP;
    assign hit_out = hit && tok.kind == TOK_OUT;

    ep_token_match u_match (
        .tok(tok),
        .function_id_register(function_id_register),
        .cfg(cfg_r),
        .tx_fifo_en(tx_fifo_en),
        .tx_fifo_empty(tx_fifo_empty),
        .hit(hit),
        .in_hs(in_hs)
    );

    // the flush only acts while no packet is landing in the fifo
    assign flush_do = flush_pend_r && state_r == ST_IDLE;
    // duplicate and dropped packets never reach the fifo
    assign fifo_push = pkt_byte_valid && (state_r == ST_RX_DATA || state_r == ST_RX_SETUP);

    ep_rx_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .rst(rst),
        .flush(flush_do),
        .push(fifo_push),
        .push_data(pkt_byte),
        .pop(fifo_pop),
        .pop_data(fifo_data),
        .full(fifo_full),
        .empty(fifo_empty),
        .count(fifo_count)
    );

    assign free_bytes = CW'(FIFO_DEPTH) - fifo_count;
    assign rx_warn = (warn_sel_r != WARN_OFF) && (free_bytes < warn_limit(warn_sel_r));

    // endpoint configuration
    always_ff @(posedge mclk) begin
        if (rst) begin
            cfg_r <= '0;
        end else if (wr_epc) begin
            cfg_r.num <= reg_wdata[EPC_NUM_HI:EPC_NUM_LO];
            cfg_r.active <= reg_wdata[EPC_ACTIVE_BIT];
            cfg_r.iso <= reg_wdata[EPC_ISO_BIT];
            cfg_r.stall <= reg_wdata[EPC_STALL_BIT];
        end
    end

    // receive control fields written by firmware
    always_ff @(posedge mclk) begin
        if (rst) begin
            skip_r <= 1'b0;
            warn_sel_r <= '0;
        end else if (wr_rxc) begin
            skip_r <= reg_wdata[RXC_SKIP_BIT];
            warn_sel_r <= reg_wdata[RXC_WARN_HI:RXC_WARN_LO];
        end
    end

    // flush request stays pending until the fifo is idle; a new request beats the clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            flush_pend_r <= 1'b0;
        end else if (wr_rxc && reg_wdata[RXC_FLUSH_BIT]) begin
            flush_pend_r <= 1'b1;
        end else if (flush_do) begin
            flush_pend_r <= 1'b0;
        end
    end

    // receive enable: firmware arms it, the endpoint disarms it; the arming write wins
    always_ff @(posedge mclk) begin
        if (rst) begin
            rx_en_r <= 1'b0;
        end else if (wr_rxc && reg_wdata[RXC_EN_BIT]) begin
            rx_en_r <= 1'b1;
        end else if (state_r == ST_RX_DATA && pkt_done) begin
            rx_en_r <= 1'b0;
        end else if (hit_out && rx_en_r && cfg_r.stall && state_r == ST_IDLE) begin
            rx_en_r <= 1'b0;
        end
    end

    // receive state machine
    always_ff @(posedge mclk) begin
        if (rst || flush_do) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (hit_setup && !skip_r) begin
                        if (setup_held_r) begin
                            state_r <= ST_SETUP_DUP;
                        end else if (flush_pend_r) begin
                            state_r <= ST_DROP;
                        end else begin
                            state_r <= ST_RX_SETUP;
                        end
                    end else if (hit_out && rx_en_r && !cfg_r.stall) begin
                        state_r <= ST_RX_DATA;
                    end
                end
                ST_RX_DATA, ST_RX_SETUP, ST_SETUP_DUP, ST_DROP: begin
                    if (pkt_done) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // a setup that lands cleanly is held until a non-setup token to this endpoint is seen
    always_ff @(posedge mclk) begin
        if (rst) begin
            setup_held_r <= 1'b0;
        end else if (state_r == ST_RX_SETUP && pkt_end_ok) begin
            setup_held_r <= 1'b1;
        end else if (hit && tok.kind != TOK_SETUP) begin
            setup_held_r <= 1'b0;
        end
    end

    // overrun inside the current data packet
    always_ff @(posedge mclk) begin
        if (rst || state_r == ST_IDLE) begin
            ovf_r <= 1'b0;
        end else if (pkt_byte_valid && fifo_full) begin
            ovf_r <= 1'b1;
        end
    end

    // setup arrival flag for firmware, cleared by reading the receive control
    always_ff @(posedge mclk) begin
        if (rst) begin
            setup_seen_r <= 1'b0;
        end else if (state_r == ST_RX_SETUP && pkt_end_ok) begin
            setup_seen_r <= 1'b1;
        end else if (reg_rd && reg_addr == RX_CTRL_OFS) begin
            setup_seen_r <= 1'b0;
        end
    end

    // handshake choice, one cycle after its cause
    always_ff @(posedge mclk) begin
        if (rst) begin
            hs_r <= '{valid: 1'b0, pid: HS_ACK};
        end else begin
            hs_r <= '{valid: 1'b0, pid: HS_ACK};
            if (in_hs.valid) begin
                hs_r <= in_hs;
            end else if (state_r == ST_IDLE && hit_out) begin
                if (rx_en_r && cfg_r.stall) begin
                    hs_r <= '{valid: 1'b1, pid: HS_STALL};
                end else if (!rx_en_r && !cfg_r.iso) begin
                    hs_r <= '{valid: 1'b1, pid: HS_NAK};
                end
            end else if (pkt_end_ok) begin
                case (state_r)
                    ST_RX_SETUP, ST_SETUP_DUP: hs_r <= '{valid: 1'b1, pid: HS_ACK};
                    ST_RX_DATA: begin
                        // isochronous data carries no handshake at all
                        if (!cfg_r.iso) begin
                            hs_r <= '{valid: 1'b1, pid: ovf_r ? HS_NAK : HS_ACK};
                        end
                    end
                    default: hs_r <= '{valid: 1'b0, pid: HS_ACK};
                endcase
            end
        end
    end

    assign hs = hs_r;
    assign setup_seen = setup_seen_r;

    // register read, answered in the next cycle; unmapped addresses read zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_r <= '0;
        end else if (reg_rd) begin
            rdata_r <= '0;
            if (reg_addr == RX_CTRL_OFS) begin
                rdata_r[RXC_EN_BIT] <= rx_en_r;
                rdata_r[RXC_SKIP_BIT] <= skip_r;
                rdata_r[RXC_FLUSH_BIT] <= flush_pend_r;
                rdata_r[RXC_WARN_HI:RXC_WARN_LO] <= warn_sel_r;
            end else if (reg_addr == EP_CFG_OFS) begin
                rdata_r[EPC_NUM_HI:EPC_NUM_LO] <= cfg_r.num;
                rdata_r[EPC_ACTIVE_BIT] <= cfg_r.active;
                rdata_r[EPC_ISO_BIT] <= cfg_r.iso;
                rdata_r[EPC_STALL_BIT] <= cfg_r.stall;
            end
        end else begin
            rdata_r <= '0;
        end
    end

    assign reg_rdata = rdata_r;

    AST_FLUSH_EMPTIES: assert property (@(posedge mclk) disable iff (rst)
        flush_do |=> fifo_empty && state_r == ST_IDLE && !flush_pend_r)
        else $error("flush did not empty the fifo");

    AST_FLUSH_WAITS: assert property (@(posedge mclk) disable iff (rst)
        flush_pend_r && state_r == ST_RX_DATA && pkt_byte_valid && !fifo_full && !fifo_pop
        |=> fifo_count == $past(fifo_count) + 1'b1)
        else $error("flush cut into a reception");

    AST_SKIP_SETUP: assert property (@(posedge mclk) disable iff (rst)
        hit_setup && skip_r && state_r == ST_IDLE |=> state_r == ST_IDLE)
        else $error("ignored setup was taken");

    AST_DISARM_AFTER_DATA: assert property (@(posedge mclk) disable iff (rst)
        state_r == ST_RX_DATA && pkt_done && !wr_rxc |=> !rx_en_r)
        else $error("reception stayed armed after a packet");

    AST_SETUP_ALWAYS: assert property (@(posedge mclk) disable iff (rst)
        hit_setup && !skip_r && state_r == ST_IDLE && !setup_held_r && !flush_pend_r
        |=> state_r == ST_RX_SETUP)
        else $error("setup refused");

    AST_DUP_SETUP_ACK: assert property (@(posedge mclk) disable iff (rst)
        state_r == ST_SETUP_DUP && pkt_end_ok |=> hs.valid && hs.pid == HS_ACK ##1 !hs.valid)
        else $error("duplicate setup not acknowledged");

    AST_DROP_SILENT: assert property (@(posedge mclk) disable iff (rst)
        state_r == ST_DROP && pkt_done && !in_hs.valid |=> !hs.valid)
        else $error("dropped setup got a handshake");

    AST_OUT_STALL: assert property (@(posedge mclk) disable iff (rst)
        state_r == ST_IDLE && hit_out && rx_en_r && cfg_r.stall && !wr_rxc
        |=> hs.valid && hs.pid == HS_STALL && !rx_en_r)
        else $error("halted out token not stalled");

    AST_SETUP_NO_STALL: assert property (@(posedge mclk) disable iff (rst)
        hs.valid && hs.pid == HS_STALL |-> $past(hit) && $past(tok.kind) != TOK_SETUP)
        else $error("stall given to a setup");

    AST_ISO_NO_NAK: assert property (@(posedge mclk) disable iff (rst)
        $past(cfg_r.iso) |-> !(hs.valid && hs.pid == HS_NAK))
        else $error("isochronous endpoint sent nak");

    AST_INACTIVE_SILENT: assert property (@(posedge mclk) disable iff (rst)
        tok.valid && !cfg_r.active && state_r == ST_IDLE |=> !hs.valid)
        else $error("inactive endpoint answered");

    AST_RESET_CLEAR: assert property (@(posedge mclk)
        $past(rst) |-> cfg_r == '0 && !rx_en_r && !skip_r && warn_sel_r == '0)
        else $error("control bits not cleared by reset");
endmodule

// [usb_host_model.sv]
// behavioural bus engine and host side that feeds tokens and packets to the endpoint
`timescale 1ns/100ps
module usb_host_model (
    // clock
    input wire logic mclk,
    // token and packet stream
    output ep_rx_pkg::token_s tok,
    output logic pkt_byte_valid,
    output logic [7:0] pkt_byte,
    output logic pkt_end_ok,
    output logic pkt_end_err,
    // transmit side state
    output logic tx_fifo_en,
    output logic tx_fifo_empty
);
    import ep_rx_pkg::*;
    initial begin
        tok = '0;
        pkt_byte_valid = 1'b0;
        pkt_byte = 8'h00;
        pkt_end_ok = 1'b0;
        pkt_end_err = 1'b0;
        tx_fifo_en = 1'b0;
        tx_fifo_empty = 1'b1;
    end
    // between pulses the fields show the inverse, so a stale value never looks valid
    task automatic send_tok(input tok_kind_e k, input logic [6:0] a, input logic [3:0] e);
        @(posedge mclk);
        tok <= '{valid: 1'b1, kind: k, dev_addr: a, ep_num: e};
        @(posedge mclk);
        tok <= '{valid: 1'b0, kind: tok_kind_e'(~k), dev_addr: ~a, ep_num: ~e};
    endtask
    // token, bytes, then end pulse: the order the engine keeps
    task automatic send_pkt(input tok_kind_e k, input logic [6:0] a, input logic [3:0] e,
                            input int n, input logic [7:0] first);
        send_tok(k, a, e);
        for (int i = 0; i < n; i++) begin
            pkt_byte_valid <= 1'b1;
            pkt_byte <= first + 8'(i);
            @(posedge mclk);
        end
        pkt_byte_valid <= 1'b0;
        pkt_byte <= ~pkt_byte;
        @(posedge mclk);
        pkt_end_ok <= 1'b1;
        @(posedge mclk);
        pkt_end_ok <= 1'b0;
    endtask
endmodule

// [tb.sv]
// self-checking testbench of the endpoint receive control
`timescale 1ns/100ps
module tb;
    import ep_rx_pkg::*;
    localparam logic [6:0] DEV = 7'h2A;
    localparam logic [3:0] EPN = 4'h5;
    localparam logic [31:0] BAD_OFS = 32'h50001872;
    logic mclk, rst, reg_wr, reg_rd, fifo_pop, rx_warn, setup_seen, hs_seen;
    logic [31:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rd_val;
    logic [7:0] fifo_data;
    logic [6:0] fifo_count;
    logic [6:0] function_id_register;
    logic pkt_byte_valid, pkt_end_ok, pkt_end_err, tx_fifo_en, tx_fifo_empty;
    logic [7:0] pkt_byte;
    token_s tok;
    handshake_s hs;
    hs_pid_e hs_got;
    int err_count, checks;

    usb_host_model host_u (.mclk(mclk), .tok(tok), .pkt_byte_valid(pkt_byte_valid),
        .pkt_byte(pkt_byte), .pkt_end_ok(pkt_end_ok), .pkt_end_err(pkt_end_err),
        .tx_fifo_en(tx_fifo_en), .tx_fifo_empty(tx_fifo_empty));
    usb_endpoint_rx_control #(.FIFO_DEPTH(64)) dut_u (.mclk(mclk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .function_id_register(function_id_register), .tok(tok),
        .pkt_byte_valid(pkt_byte_valid), .pkt_byte(pkt_byte), .pkt_end_ok(pkt_end_ok),
        .pkt_end_err(pkt_end_err), .tx_fifo_en(tx_fifo_en), .tx_fifo_empty(tx_fifo_empty),
        .hs(hs), .fifo_pop(fifo_pop), .fifo_data(fifo_data), .fifo_count(fifo_count),
        .rx_warn(rx_warn), .setup_seen(setup_seen));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (hs.valid === 1'b1) begin
            hs_seen <= 1'b1;
            hs_got <= hs.pid;
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [31:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask
    // the handshake comes one cycle after its cause; three cycles leave margin
    task automatic exp_hs(input logic want, input hs_pid_e p, input string m);
        repeat (3) @(posedge mclk);
        #1 chk({14'h0, hs_seen, (want && hs_got !== p)}, {14'h0, want, 1'b0}, m);
        hs_seen = 1'b0;
    endtask
    task automatic pop();
        @(posedge mclk);
        fifo_pop <= 1'b1;
        @(posedge mclk);
        fifo_pop <= 1'b0;
        #1;
    endtask

    task automatic t_reset_cfg();
        rd(RX_CTRL_OFS);
        chk(rd_val, 16'h0000, "rx ctrl reset");
        rd(EP_CFG_OFS);
        chk(rd_val, 16'h0000, "ep cfg reset");
        rd(BAD_OFS);
        chk(rd_val, 16'h0000, "unmapped read");
        wr(EP_CFG_OFS, 16'hFFFF);
        rd(EP_CFG_OFS);
        chk(rd_val, 16'h00BF, "cfg fields");
        wr(EP_CFG_OFS, 16'h0015);
        $display("test reset_cfg done");
    endtask
    task automatic t_out();
        host_u.send_tok(TOK_OUT, DEV, EPN);
        exp_hs(1'b1, HS_NAK, "out disarmed");
        wr(RX_CTRL_OFS, 16'h0001);
        host_u.send_pkt(TOK_OUT, DEV, EPN, 3, 8'h10);
        exp_hs(1'b1, HS_ACK, "out ack");
        rd(RX_CTRL_OFS);
        chk(rd_val, 16'h0000, "disarm after data");
        pop();
        chk(16'(fifo_data), 16'h0010, "first byte");
        chk(16'(fifo_count), 16'h0002, "count after pop");
        // the pending flush acts at the first idle edge after the write
        wr(RX_CTRL_OFS, 16'h0008);
        @(posedge mclk);
        #1 chk(16'(fifo_count), 16'h0000, "flush");
        wr(RX_CTRL_OFS, 16'h0001);
        host_u.send_tok(TOK_OUT, DEV, EPN);
        repeat (2) @(posedge mclk);
        wr(RX_CTRL_OFS, 16'h0009);
        rd(RX_CTRL_OFS);
        chk(rd_val, 16'h0009, "flush pending");
        host_u.send_pkt(TOK_OTHER, 7'h00, 4'h0, 4, 8'h20);
        rd(RX_CTRL_OFS);
        chk(16'(fifo_count), 16'h0000, "flush after rx");
        hs_seen = 1'b0;
        $display("test out_flush done");
    endtask
    task automatic t_setup();
        host_u.send_pkt(TOK_SETUP, DEV, EPN, 8, 8'h40);
        exp_hs(1'b1, HS_ACK, "setup");
        chk(16'(setup_seen), 16'h0001, "setup seen");
        host_u.send_pkt(TOK_SETUP, DEV, EPN, 8, 8'h50);
        exp_hs(1'b1, HS_ACK, "dup");
        chk(16'(fifo_count), 16'h0008, "dup dropped");
        wr(RX_CTRL_OFS, 16'h000C);
        host_u.send_pkt(TOK_SETUP, DEV, EPN, 8, 8'h60);
        exp_hs(1'b0, HS_ACK, "skip");
        chk(16'(fifo_count), 16'h0000, "skip no data");
        $display("test setup done");
    endtask
    task automatic t_halt_iso();
        wr(EP_CFG_OFS, 16'h0095);
        wr(RX_CTRL_OFS, 16'h0001);
        host_u.send_tok(TOK_OUT, DEV, EPN);
        exp_hs(1'b1, HS_STALL, "out stall");
        rd(RX_CTRL_OFS);
        chk(rd_val, 16'h0000, "disarm after stall");
        host_u.tx_fifo_en <= 1'b1;
        host_u.send_tok(TOK_IN, DEV, EPN);
        exp_hs(1'b1, HS_STALL, "in stall");
        host_u.send_pkt(TOK_SETUP, DEV, EPN, 8, 8'h70);
        exp_hs(1'b1, HS_ACK, "halt setup");
        wr(EP_CFG_OFS, 16'h0015);
        host_u.send_tok(TOK_IN, DEV, EPN);
        exp_hs(1'b1, HS_NAK, "in empty");
        // with data waiting the transmit side answers, not this block
        host_u.tx_fifo_empty <= 1'b0;
        host_u.send_tok(TOK_IN, DEV, EPN);
        exp_hs(1'b0, HS_NAK, "in with data");
        host_u.tx_fifo_empty <= 1'b1;
        wr(EP_CFG_OFS, 16'h0035);
        host_u.send_tok(TOK_IN, DEV, EPN);
        exp_hs(1'b0, HS_NAK, "iso in");
        host_u.send_tok(TOK_OUT, DEV, EPN);
        exp_hs(1'b0, HS_NAK, "iso out");
        wr(EP_CFG_OFS, 16'h0005);
        host_u.send_tok(TOK_OUT, DEV, EPN);
        exp_hs(1'b0, HS_NAK, "inactive");
        wr(EP_CFG_OFS, 16'h0015);
        host_u.send_tok(TOK_OUT, DEV, 4'h6);
        exp_hs(1'b0, HS_NAK, "other ep");
        host_u.send_tok(TOK_OUT, 7'h2B, EPN);
        exp_hs(1'b0, HS_NAK, "other dev");
        $display("test halt_iso done");
    endtask
    // 48 of 64 bytes leaves 16 free: under the largest limit, not under the middle one
    task automatic t_warn();
        wr(RX_CTRL_OFS, 16'h0068);
        wr(RX_CTRL_OFS, 16'h0061);
        host_u.send_pkt(TOK_OUT, DEV, EPN, 48, 8'h00);
        exp_hs(1'b1, HS_ACK, "fill");
        chk(16'(rx_warn), 16'h0001, "warn on");
        wr(RX_CTRL_OFS, 16'h0040);
        #1 chk(16'(rx_warn), 16'h0000, "warn 9");
        wr(RX_CTRL_OFS, 16'h0060);
        pop();
        chk(16'(rx_warn), 16'h0000, "warn off");
        wr(RX_CTRL_OFS, 16'h0020);
        #1 chk(16'(rx_warn), 16'h0000, "warn 5");
        // 47 held plus 20 more overruns the fifo by three bytes
        wr(RX_CTRL_OFS, 16'h0001);
        host_u.send_pkt(TOK_OUT, DEV, EPN, 20, 8'h80);
        exp_hs(1'b1, HS_NAK, "overrun");
        chk(16'(fifo_count), 16'h0040, "fifo full");
        $display("test warn done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // a hang anywhere is cut short here
    initial begin
        #900000;
        err_count++;
        $display("mismatch at %0t: run too long", $time);
        tally_and_finish();
    end
    initial begin
        rst = 1'b1;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        fifo_pop = 1'b0;
        hs_seen = 1'b0;
        function_id_register = DEV;
        err_count = 0;
        checks = 0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        t_reset_cfg();
        t_out();
        t_setup();
        t_halt_iso();
        t_warn();
        tally_and_finish();
    end
endmodule
